// File: rtl/cmcs_pkg.sv
// Shared constants and types for the converter mode, configuration and status block
package cmcs_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned DB_TIME_MS     = 5;
   localparam int unsigned DB_CYCLES      = DB_TIME_MS * CLK_PER_MS;
   localparam int unsigned BLINK_HALF_MS  = 250;
   localparam int unsigned BLINK_CYCLES   = BLINK_HALF_MS * CLK_PER_MS;
   localparam int unsigned INIT_LED_MS    = 200;
   localparam int unsigned INIT_CYCLES    = INIT_LED_MS * CLK_PER_MS;
   localparam int unsigned CNT_W          = 26;

   // ----------------------------------------------------------------
   // Switch field positions (bit 0 is switch 1, 1 = ON)
   // ----------------------------------------------------------------
   localparam int unsigned DIP_MODE_LSB   = 0;
   localparam int unsigned DIP_BAUD_LSB   = 3;
   localparam int unsigned DIP_AREA_LSB   = 5;

   // ----------------------------------------------------------------
   // Mode codes, switch 1 is the most significant bit
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_SERIAL     = 3'h0;
   localparam logic [2:0] MODE_HET_CV     = 3'h1;
   localparam logic [2:0] MODE_RSVD_A     = 3'h2;
   localparam logic [2:0] MODE_BATT_AUTO  = 3'h3;
   localparam logic [2:0] MODE_GRID_AUTO  = 3'h4;
   localparam logic [2:0] MODE_HET_BCC    = 3'h5;
   localparam logic [2:0] MODE_GRID_BCC   = 3'h6;
   localparam logic [2:0] MODE_RSVD_B     = 3'h7;

   // Baud codes, switch 4 is the most significant bit
   localparam logic [1:0] BAUD_19200      = 2'h0;
   localparam logic [1:0] BAUD_38400      = 2'h1;
   localparam logic [1:0] BAUD_57600      = 2'h2;
   localparam logic [1:0] BAUD_9600       = 2'h3;

   // ----------------------------------------------------------------
   // Address and reset values
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_MAX        = 7'h7e;
   localparam logic [3:0] ADDR_BCAST_LOW  = 4'hf;
   localparam logic [6:0] ADDR_RST        = 7'h00;
   localparam logic [2:0] MODE_RST        = MODE_SERIAL;
   localparam logic [1:0] BAUD_RST        = BAUD_19200;

   // ----------------------------------------------------------------
   // Grouped signals
   // ----------------------------------------------------------------
   typedef struct packed {
      logic go;
      logic halt;
      logic charge_direction_in;
      logic fault_clear_in;
      logic panel_btn;
   } cmcs_contact_t;

   typedef struct packed {
      logic grid_precharged;
      logic grid_below_regen;
      logic grid_above_gen;
      logic batt_below_tgt;
      logic batt_above_tgt;
      logic batt_at_ovc;
      logic batt_at_ovd;
      logic no_load;
      logic internal_fail;
   } cmcs_sense_t;

   typedef struct packed {
      logic fault;
      logic run;
      logic direction_indicator_led;
   } cmcs_led_t;

   typedef enum logic [0:0] {ST_INIT, ST_READY} cmcs_state_t;

endpackage

// File: rtl/cmcs_top.sv
// Converter mode, configuration and status logic
`timescale 1ns/100ps
module cmcs_top #(
   parameter int unsigned DB_CYC    = cmcs_pkg::DB_CYCLES,
   parameter int unsigned BLINK_CYC = cmcs_pkg::BLINK_CYCLES,
   parameter int unsigned INIT_CYC  = cmcs_pkg::INIT_CYCLES
) (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   // Panel and rear switches
   input  wire logic [7:0]             dip_sw_in,
   input  wire logic [3:0]             rotary_sw_in,
   // Contact inputs, 1 = shorted to signal_return
   input  wire cmcs_pkg::cmcs_contact_t contact_in,
   // Analog comparator and health status
   input  wire cmcs_pkg::cmcs_sense_t  sense_in,
   // Configuration and serial command (same clock)
   input  wire logic                   init_req,
   input  wire logic                   batt_prot_en,
   input  wire logic                   dir_from_serial,
   input  wire logic                   ser_run,
   input  wire logic                   ser_charge,
   input  wire logic                   fault_event,
   input  wire logic [6:0]             rx_addr,
   // Configuration outputs
   output logic [2:0]                  mode_ff,
   output logic [1:0]                  baud_sel_ff,
   output logic [6:0]                  bus_addr_ff,
   output logic                        addr_valid_ff,
   output logic                        addr_match_ff,
   output logic                        init_busy_ff,
   // Conversion control
   output logic                        conv_en_ff,
   output logic                        dir_charge_ff,
   output logic                        cv_on_batt_ff,
   output logic                        cc_on_batt_ff,
   // Contacts and indicators
   output logic                        fault_contact_out,
   output logic                        conversion_good_out,
   output cmcs_pkg::cmcs_led_t         led_ff
);
   import cmcs_pkg::*;

   localparam int unsigned NDB = 17;
   localparam int unsigned NSN = 9;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic addr_hits(input logic [6:0] own, input logic [6:0] rx);
      logic bc;
      bc = (rx[3:0] == ADDR_BCAST_LOW) && (rx <= ADDR_MAX);
      return bc || (rx == own);
   endfunction

   function automatic logic [CNT_W-1:0] lim(input int unsigned n);
      return (n > 1) ? CNT_W'(n - 1) : '0;
   endfunction

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   logic [NDB-1:0] db_meta_ff;
   logic [NDB-1:0] db_sync_ff;
   logic [NSN-1:0] sn_meta_ff;
   logic [NSN-1:0] sn_sync_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         db_meta_ff <= '0;
         db_sync_ff <= '0;
         sn_meta_ff <= '0;
         sn_sync_ff <= '0;
      end else begin
         db_meta_ff <= {dip_sw_in, rotary_sw_in, contact_in};
         db_sync_ff <= db_meta_ff;
         sn_meta_ff <= sense_in;
         sn_sync_ff <= sn_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // Debounce
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] db_cnt_ff [NDB];
   logic [NDB-1:0]   db_ff;
   logic [NDB-1:0]   db_prev_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         db_ff      <= '0;
         db_prev_ff <= '0;
         for (int i = 0; i < NDB; i++) begin
            db_cnt_ff[i] <= '0;
         end
      end else begin
         db_prev_ff <= db_ff;
         for (int i = 0; i < NDB; i++) begin
            if (db_sync_ff[i] == db_ff[i]) begin
               db_cnt_ff[i] <= '0;
            end else if (db_cnt_ff[i] >= lim(DB_CYC)) begin
               db_ff[i]     <= db_sync_ff[i];
               db_cnt_ff[i] <= '0;
            end else begin
               db_cnt_ff[i] <= db_cnt_ff[i] + 1'b1;
            end
         end
      end
   end

   cmcs_contact_t ct;
   cmcs_contact_t ct_prev;
   cmcs_sense_t   sn;
   logic [7:0]    dip_db;
   logic [3:0]    rot_db;

   assign ct      = db_ff[4:0];
   assign ct_prev = db_prev_ff[4:0];
   assign rot_db  = db_ff[8:5];
   assign dip_db  = db_ff[16:9];
   assign sn      = sn_sync_ff;

   // ----------------------------------------------------------------
   // Initialisation and switch sampling
   // ----------------------------------------------------------------
   cmcs_state_t      state_ff;
   logic [CNT_W-1:0] init_cnt_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff    <= ST_INIT;
         init_cnt_ff <= '0;
      end else begin
         unique case (state_ff)
            ST_INIT: begin
               if (init_cnt_ff >= lim(INIT_CYC)) begin
                  state_ff <= ST_READY;
               end else begin
                  init_cnt_ff <= init_cnt_ff + 1'b1;
               end
            end
            ST_READY: begin
               if (init_req) begin
                  state_ff    <= ST_INIT;
                  init_cnt_ff <= '0;
               end
            end
         endcase
      end
   end

   logic init_end;
   logic [6:0] nxt_addr;
   assign init_end = (state_ff == ST_INIT) && (init_cnt_ff >= lim(INIT_CYC));
   assign nxt_addr = {dip_db[DIP_AREA_LSB], dip_db[DIP_AREA_LSB+1],
                      dip_db[DIP_AREA_LSB+2], rot_db};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_ff       <= MODE_RST;
         baud_sel_ff   <= BAUD_RST;
         bus_addr_ff   <= ADDR_RST;
         addr_valid_ff <= 1'b1;
      end else if (init_end) begin
         mode_ff       <= {dip_db[DIP_MODE_LSB], dip_db[DIP_MODE_LSB+1],
                           dip_db[DIP_MODE_LSB+2]};
         baud_sel_ff   <= {dip_db[DIP_BAUD_LSB], dip_db[DIP_BAUD_LSB+1]};
         bus_addr_ff   <= nxt_addr;
         addr_valid_ff <= (nxt_addr[3:0] != ADDR_BCAST_LOW) && (nxt_addr <= ADDR_MAX);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_match_ff <= 1'b0;
         init_busy_ff  <= 1'b1;
      end else begin
         addr_match_ff <= addr_hits(bus_addr_ff, rx_addr);
         init_busy_ff  <= (state_ff == ST_INIT);
      end
   end

   // ----------------------------------------------------------------
   // Alarm latch
   // ----------------------------------------------------------------
   logic alarm_ff;
   logic alm_set;
   logic alm_clr;

   assign alm_set = fault_event || ct.halt || sn.internal_fail;
   assign alm_clr = (ct_prev.fault_clear_in && !ct.fault_clear_in)
                 || (alarm_ff && ct.panel_btn && !ct_prev.panel_btn);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         alarm_ff <= 1'b0;
      end else if (alm_set) begin
         alarm_ff <= 1'b1;
      end else if (alm_clr) begin
         alarm_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Direction and run decision
   // ----------------------------------------------------------------
   logic want_run;
   logic want_chg;
   logic idle_band;
   logic het_ctl;
   logic mode_ok;

   always_comb begin
      want_chg  = 1'b0;
      idle_band = 1'b0;
      het_ctl   = 1'b0;
      mode_ok   = 1'b1;
      want_run  = ct.go;
      unique case (mode_ff)
         MODE_SERIAL: begin
            want_run = ser_run;
            want_chg = ser_charge;
         end
         MODE_HET_CV, MODE_HET_BCC: begin
            het_ctl  = 1'b1;
            want_chg = dir_from_serial ? ser_charge : ct.charge_direction_in;
         end
         MODE_BATT_AUTO: begin
            want_chg  = sn.batt_below_tgt;
            idle_band = !sn.batt_below_tgt && !sn.batt_above_tgt;
         end
         MODE_GRID_AUTO, MODE_GRID_BCC: begin
            if (ct.charge_direction_in) begin
               het_ctl  = 1'b1;
               want_chg = 1'b1;
            end else begin
               want_chg  = sn.grid_above_gen;
               idle_band = !sn.grid_above_gen && !sn.grid_below_regen;
            end
         end
         default: begin
            mode_ok = 1'b0;
         end
      endcase
   end

   logic prot_stop;
   logic run_ok;
   assign prot_stop = batt_prot_en && (want_chg ? sn.batt_at_ovc : sn.batt_at_ovd);
   assign run_ok    = want_run && mode_ok && !idle_band && !prot_stop
                   && !alarm_ff && !ct.halt && (state_ff == ST_READY);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         conv_en_ff    <= 1'b0;
         dir_charge_ff <= 1'b0;
         cv_on_batt_ff <= 1'b0;
         cc_on_batt_ff <= 1'b0;
      end else begin
         conv_en_ff    <= run_ok && (conv_en_ff || sn.grid_precharged);
         dir_charge_ff <= want_chg;
         cv_on_batt_ff <= het_ctl && want_chg;
         cc_on_batt_ff <= (mode_ff == MODE_GRID_BCC)
                       || ((mode_ff == MODE_HET_BCC) && !want_chg);
      end
   end

   // ----------------------------------------------------------------
   // Blink timer
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] blink_cnt_ff;
   logic             blink_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         blink_cnt_ff <= '0;
         blink_ff     <= 1'b0;
      end else if (blink_cnt_ff >= lim(BLINK_CYC)) begin
         blink_cnt_ff <= '0;
         blink_ff     <= !blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Contacts and LEDs
   // ----------------------------------------------------------------
   logic all_on;
   assign all_on = sn.internal_fail || (state_ff == ST_INIT);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fault_contact_out   <= 1'b0;
         conversion_good_out <= 1'b0;
         led_ff              <= '0;
      end else begin
         fault_contact_out   <= alarm_ff || sn.internal_fail;
         conversion_good_out <= run_ok && (conv_en_ff || sn.grid_precharged);
         led_ff.fault        <= all_on || alarm_ff;
         led_ff.run          <= all_on || conv_en_ff;
         led_ff.direction_indicator_led <= all_on
            || (conv_en_ff && (!sn.no_load || blink_ff));
      end
   end

endmodule

// File: sim/cmcs_props.sv
// Concurrent checks on the ports of the mode, configuration and status block
`timescale 1ns/100ps
module cmcs_props
   import cmcs_pkg::*;
#(
   parameter int unsigned DB_CYC = 4
) (
   // Clock and reset
   input wire logic          core_clk,
   input wire logic          rst,
   // Watched inputs
   input wire cmcs_contact_t contact_in,
   input wire cmcs_sense_t   sense_in,
   input wire logic          fault_event,
   // Watched outputs
   input wire logic [2:0]    mode_ff,
   input wire logic [6:0]    bus_addr_ff,
   input wire logic          addr_valid_ff,
   input wire logic          init_busy_ff,
   input wire logic          conv_en_ff,
   input wire logic          fault_contact_out,
   input wire logic          conversion_good_out,
   input wire cmcs_led_t     led_ff
);
   // ----------------------------------------------------------------
   // Halt hold counter
   // ----------------------------------------------------------------
   logic [7:0] halt_cnt_ff;
   always_ff @(posedge core_clk) begin
      if (rst || !contact_in.halt) halt_cnt_ff <= 8'h00;
      else if (halt_cnt_ff != 8'hff) halt_cnt_ff <= halt_cnt_ff + 8'h01;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_rst_cfg; $fell(rst) |-> bus_addr_ff == ADDR_RST && mode_ff == MODE_RST; endproperty
   a_rst_cfg: assert property (p_rst_cfg) else $error("config not cleared by reset");
   property p_addr_ok; addr_valid_ff == (bus_addr_ff[3:0] != ADDR_BCAST_LOW); endproperty
   a_addr_ok: assert property (p_addr_ok) else $error("address valid flag wrong");
   property p_cfg_hold;
      !init_busy_ff && !$past(init_busy_ff) |-> $stable(mode_ff) && $stable(bus_addr_ff);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed outside init");
   property p_rsvd; conv_en_ff |-> mode_ff != MODE_RSVD_A && mode_ff != MODE_RSVD_B; endproperty
   a_rsvd: assert property (p_rsvd) else $error("conversion in reserved mode");
   property p_good; conversion_good_out == conv_en_ff && (!$past(conv_en_ff) || led_ff.run); endproperty
   a_good: assert property (p_good) else $error("good contact not following conversion");
   property p_alm_led;
      !init_busy_ff && !$past(init_busy_ff, 2) |-> fault_contact_out == led_ff.fault;
   endproperty
   a_alm_led: assert property (p_alm_led) else $error("alarm contact and led differ");
   property p_evt; fault_event |-> ##2 (fault_contact_out && !conv_en_ff); endproperty
   a_evt: assert property (p_evt) else $error("fault event did not raise alarm");
   property p_halt; int'(halt_cnt_ff) > DB_CYC + 8 |-> !conv_en_ff && fault_contact_out; endproperty
   a_halt: assert property (p_halt) else $error("halt did not stop conversion");
   property p_fail; sense_in.internal_fail [*5] |-> led_ff == 3'h7; endproperty
   a_fail: assert property (p_fail) else $error("internal failure not on all leds");
endmodule

// File: sim/cmcs_host.sv
// Host side model driving contact closures and converter sense levels
`timescale 1ns/100ps
module cmcs_host
   import cmcs_pkg::*;
(
   // Clock
   input wire logic    core_clk,
   // Levels seen by the block
   output cmcs_contact_t contact_in,
   output cmcs_sense_t   sense_in
);
   initial begin
      contact_in = '0;
      sense_in = '0;
   end
   // Grid port charged first, contacts one cycle later
   task automatic drive(input cmcs_contact_t c, input cmcs_sense_t s);
      @(negedge core_clk);
      sense_in = s;
      @(negedge core_clk);
      contact_in = c;
   endtask
endmodule

// File: sim/tb.sv
// Self-checking testbench for the mode, configuration and status block
`timescale 1ns/100ps
module tb;
   import cmcs_pkg::*;
   localparam int unsigned DB = 4;
   localparam int unsigned BL = 8;
   localparam int unsigned STL = DB + 8;
   logic          core_clk = 1'b0;
   logic          rst = 1'b1;
   logic [7:0]    dip_sw_in = 8'h00;
   logic [3:0]    rotary_sw_in = 4'h0;
   cmcs_contact_t contact_in;
   cmcs_sense_t   sense_in;
   logic          init_req = 1'b0;
   logic          batt_prot_en = 1'b0;
   logic          dir_from_serial = 1'b0;
   logic          ser_run = 1'b0;
   logic          ser_charge = 1'b0;
   logic          fault_event = 1'b0;
   logic [6:0]    rx_addr = 7'h00;
   logic [2:0]    mode_ff;
   logic [1:0]    baud_sel_ff;
   logic [6:0]    bus_addr_ff;
   logic          addr_valid_ff, addr_match_ff, init_busy_ff;
   logic          conv_en_ff, dir_charge_ff, cv_on_batt_ff, cc_on_batt_ff;
   logic          fault_contact_out, conversion_good_out;
   cmcs_led_t     led_ff;
   int            errors = 0;
   int            tests_run = 0;
   int            ones;
   logic [3:0]    rot;
   always #4 core_clk = ~core_clk;
   cmcs_host host (.core_clk(core_clk), .contact_in(contact_in), .sense_in(sense_in));
   cmcs_top #(.DB_CYC(DB), .BLINK_CYC(BL), .INIT_CYC(16)) uut (
      .core_clk(core_clk), .rst(rst), .dip_sw_in(dip_sw_in), .rotary_sw_in(rotary_sw_in),
      .contact_in(contact_in), .sense_in(sense_in), .init_req(init_req), .batt_prot_en(batt_prot_en),
      .dir_from_serial(dir_from_serial), .ser_run(ser_run), .ser_charge(ser_charge),
      .fault_event(fault_event), .rx_addr(rx_addr), .mode_ff(mode_ff), .baud_sel_ff(baud_sel_ff),
      .bus_addr_ff(bus_addr_ff), .addr_valid_ff(addr_valid_ff), .addr_match_ff(addr_match_ff),
      .init_busy_ff(init_busy_ff), .conv_en_ff(conv_en_ff), .dir_charge_ff(dir_charge_ff),
      .cv_on_batt_ff(cv_on_batt_ff), .cc_on_batt_ff(cc_on_batt_ff),
      .fault_contact_out(fault_contact_out), .conversion_good_out(conversion_good_out), .led_ff(led_ff));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 40 && init_busy_ff !== 1'b0; k++) cyc(1);
      chk("init_busy", 8'(init_busy_ff), 8'h00);
   endtask
   task automatic do_init(input logic [7:0] dip, input logic [3:0] r);
      dip_sw_in = dip;
      rotary_sw_in = r;
      init_req = 1'b1;
      cyc(1);
      init_req = 1'b0;
      cyc(2);
      wait_idle();
   endtask
   task automatic close_out();
      if (errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [7:0] dip_of(input logic [2:0] m, input logic [1:0] b, input logic [2:0] a);
      return {a[0], a[1], a[2], b[0], b[1], m[0], m[1], m[2]};
   endfunction
   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   initial begin
      #100_000;
      errors++;
      close_out();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(4);
      rst = 1'b0;
      chk("rst_addr", 8'(bus_addr_ff), 8'h00);
      wait_idle();
      for (int i = 0; i < 8; i++) begin
         rot = (i == 7) ? 4'hf : 4'(i + 5);
         do_init(dip_of(3'(i), 2'(i), 3'(7 - i)), rot);
         chk("mode", 8'(mode_ff), 8'(i));
         chk("baud", 8'(baud_sel_ff), 8'(i % 4));
         chk("addr", 8'(bus_addr_ff), {1'b0, 3'(7 - i), rot});
         chk("addr_ok", 8'(addr_valid_ff), 8'(rot != 4'hf));
         chk("batt_cc", 8'(cc_on_batt_ff), 8'(i == 5 || i == 6));
      end
      do_init(dip_of(MODE_HET_CV, BAUD_9600, 3'h7), 4'he);
      chk("addr_max", 8'(bus_addr_ff), 8'h7e);
      dip_sw_in = 8'hff;
      rotary_sw_in = 4'h0;
      cyc(STL);
      chk("held_cfg", {mode_ff, bus_addr_ff[4:0]}, {3'h1, 5'h1e});
      rx_addr = 7'h7e;
      cyc(2);
      chk("match_own", 8'(addr_match_ff), 8'h01);
      rx_addr = 7'h0f;
      cyc(2);
      chk("match_bcast", 8'(addr_match_ff), 8'h01);
      rx_addr = 7'h7d;
      cyc(2);
      chk("match_other", 8'(addr_match_ff), 8'h00);
      host.drive(5'b10000, 9'h000);
      cyc(STL);
      chk("no_precharge", 8'(conv_en_ff), 8'h00);
      host.drive(5'b10100, 9'h100);
      cyc(STL);
      chk("het_chg", {conv_en_ff, dir_charge_ff, cv_on_batt_ff, conversion_good_out}, 8'h0f);
      host.drive(5'b10000, 9'h100);
      cyc(STL);
      chk("het_dis", {conv_en_ff, dir_charge_ff, cv_on_batt_ff}, 8'h04);
      dir_from_serial = 1'b1;
      ser_charge = 1'b1;
      cyc(STL);
      chk("ser_dir", 8'(dir_charge_ff), 8'h01);
      dir_from_serial = 1'b0;
      host.drive(5'b11000, 9'h100);
      cyc(STL);
      chk("halt", {conv_en_ff, fault_contact_out, led_ff.fault}, 8'h03);
      host.drive(5'b10000, 9'h100);
      cyc(STL);
      chk("latched", 8'(fault_contact_out), 8'h01);
      host.drive(5'b10010, 9'h100);
      cyc(STL);
      host.drive(5'b10000, 9'h100);
      cyc(STL);
      chk("cleared", {conv_en_ff, fault_contact_out}, 8'h02);
      host.drive(5'b10001, 9'h100);
      cyc(STL);
      fault_event = 1'b1;
      cyc(1);
      fault_event = 1'b0;
      cyc(STL);
      chk("btn_held", 8'(fault_contact_out), 8'h01);
      host.drive(5'b10000, 9'h100);
      cyc(STL);
      host.drive(5'b10001, 9'h100);
      cyc(STL);
      chk("btn_clear", {conv_en_ff, fault_contact_out}, 8'h02);
      batt_prot_en = 1'b1;
      host.drive(5'b10100, 9'h108);
      cyc(STL);
      chk("prot_stop", 8'(conv_en_ff), 8'h00);
      batt_prot_en = 1'b0;
      host.drive(5'b10000, 9'h102);
      cyc(STL);
      ones = 0;
      repeat (2 * BL + 2) begin
         cyc(1);
         ones += int'(led_ff.direction_indicator_led);
      end
      chk("blink", 8'(ones > 0 && ones < 2 * BL + 2), 8'h01);
      host.drive(5'b00000, 9'h100);
      do_init(dip_of(MODE_GRID_AUTO, BAUD_19200, 3'h0), 4'h0);
      host.drive(5'b10000, 9'h180);
      cyc(STL);
      chk("grid_low", {conv_en_ff, dir_charge_ff}, 8'h02);
      host.drive(5'b10000, 9'h140);
      cyc(STL);
      chk("grid_high", {conv_en_ff, dir_charge_ff}, 8'h03);
      host.drive(5'b10000, 9'h100);
      cyc(STL);
      chk("dead_band", 8'(conv_en_ff), 8'h00);
      host.drive(5'b10100, 9'h100);
      cyc(STL);
      chk("forced_chg", {conv_en_ff, dir_charge_ff}, 8'h03);
      do_init(dip_of(MODE_RSVD_B, BAUD_19200, 3'h0), 4'h0);
      cyc(STL);
      chk("rsvd_idle", 8'(conv_en_ff), 8'h00);
      ser_run = 1'b1;
      do_init(dip_of(MODE_SERIAL, BAUD_19200, 3'h0), 4'h0);
      cyc(STL);
      chk("ser_run", {conv_en_ff, dir_charge_ff}, 8'h03);
      host.drive(5'b01000, 9'h100);
      cyc(STL);
      chk("halt_ser", {conv_en_ff, fault_contact_out}, 8'h01);
      host.drive(5'b00000, 9'h101);
      cyc(STL);
      chk("fail_leds", 8'(led_ff), 8'h07);
      close_out();
   end
endmodule
bind cmcs_top cmcs_props #(.DB_CYC(DB_CYC)) u_props (
   .core_clk(core_clk), .rst(rst), .contact_in(contact_in), .sense_in(sense_in),
   .fault_event(fault_event), .mode_ff(mode_ff), .bus_addr_ff(bus_addr_ff),
   .addr_valid_ff(addr_valid_ff), .init_busy_ff(init_busy_ff), .conv_en_ff(conv_en_ff),
   .fault_contact_out(fault_contact_out), .conversion_good_out(conversion_good_out), .led_ff(led_ff));
